// ===== logic/cmpsel_cfg.svh
// constants for the comparator input select register bank
// What this block does
// - zero-select register at index 0x9F: negative bits 7:4, positive 3:0, reset all ones
// - one-select register at index 0x9E, same layout, read/write, reset all ones
// - negative codes 0-7 pick odd P0/P1 pins, 8-10 pick P2.1/P2.3/P2.5
// - negative 1011 reserved, 1100 touch reference, 1101 half supply, 1110 digital, 1111 ground
// - positive codes 0-7 pick even P0/P1 pins, 8-11 pick P2.0 to P2.6
// - positive 1100 touch reference, 1101 half supply, 1110 battery, 1111 main supply
// - comparator-one fields decode exactly like the comparator-zero fields
// - half-supply divider enabled only while some field holds the divided-supply code
`ifndef CMPSEL_CFG_SVH
`define CMPSEL_CFG_SVH

`define CMPSEL_IDX_ONE 8'h9E
`define CMPSEL_IDX_ZERO 8'h9F
`define CMPSEL_RESET 8'hFF
`define CMPSEL_LINES_RESET 16'h8000
`define CMPSEL_NEG_MSB 7
`define CMPSEL_NEG_LSB 4
`define CMPSEL_POS_MSB 3
`define CMPSEL_POS_LSB 0
`define CMPSEL_CODE_HALF 4'hD
`define CMPSEL_NEG_RSVD_MASK 16'h0800
`define CMPSEL_POS_RSVD_MASK 16'h0000
`define CMPSEL_RESP_OKAY 2'h0
`define CMPSEL_RESP_SLVERR 2'h2

`endif

// ===== logic/cmpsel_pkg.sv
// types shared by the comparator input select bank
`default_nettype none
package cmpsel_pkg;
  typedef logic [3:0] sel_code_t;
  typedef logic [15:0] sel_lines_t;
  typedef logic [7:0] sel_byte_t;
  typedef enum {HIT_NONE, HIT_ZERO, HIT_ONE} reg_hit_t;
endpackage
`default_nettype wire

// ===== logic/sel_if.sv
// select code and decoded lines between register file and decoder
`default_nettype none
interface sel_if;
  import cmpsel_pkg::*;
  sel_code_t code;
  sel_lines_t lines;
  logic half_req;
  modport src (output code, input lines, input half_req);
  modport dec (input code, output lines, output half_req);
endinterface
`default_nettype wire

// ===== logic/sel_reg.sv
// one 8-bit select register with byte write
`include "cmpsel_cfg.svh"
`default_nettype none
module sel_reg
  import cmpsel_pkg::*;
(
  input wire logic clock_i, // system clock
  input wire logic rst_n_i, // sync reset, active low
  input wire logic wr_en_i, // write strobe
  input wire sel_byte_t wr_data_i, // write byte
  output logic [7:0] q_o // stored value
);
  sel_byte_t q_ff;
  sel_byte_t nxt_q;

  always_comb begin
    nxt_q = q_ff;
    if (wr_en_i) begin
      nxt_q = wr_data_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      q_ff <= `CMPSEL_RESET;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign q_o = q_ff;
endmodule
`default_nettype wire

// ===== logic/input_select_decoder.sv
// one-hot decoder for one 4-bit multiplexer select field
`include "cmpsel_cfg.svh"
`default_nettype none
module input_select_decoder
  import cmpsel_pkg::*;
#(
  parameter sel_lines_t RESERVED_MASK = 16'h0000
)(
  input wire logic clock_i, // system clock
  input wire logic rst_n_i, // sync reset, active low
  sel_if.dec sel // code in, lines out
);
  sel_lines_t lines_ff;
  sel_lines_t nxt_lines;
  logic half_ff;
  logic nxt_half;

  // line n carries source n of the multiplexer
  always_comb begin
    nxt_lines = (sel_lines_t'(16'h0001) << sel.code) & ~RESERVED_MASK;
    nxt_half = (sel.code == `CMPSEL_CODE_HALF);
  end

  // lines reset to the all-ones code, so ground or main supply is picked
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      lines_ff <= `CMPSEL_LINES_RESET;
      half_ff <= 1'b0;
    end else begin
      lines_ff <= nxt_lines;
      half_ff <= nxt_half;
    end
  end

  assign sel.lines = lines_ff;
  assign sel.half_req = half_ff;
endmodule
`default_nettype wire

// ===== logic/comparator_input_select_regs.sv
// comparator input select registers behind an AXI4-Lite slave
`include "cmpsel_cfg.svh"
`default_nettype none
module comparator_input_select_regs
  import cmpsel_pkg::*;
#(
  parameter int ADDR_W = 12
)(
  input wire logic clock_i, // system clock, 100 MHz
  input wire logic rst_n_i, // sync reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i, // write address
  input wire logic s_axi_awvalid_i, // write address valid
  output logic s_axi_awready_o, // write address ready
  input wire logic [31:0] s_axi_wdata_i, // write data
  input wire logic [3:0] s_axi_wstrb_i, // write byte enables
  input wire logic s_axi_wvalid_i, // write data valid
  output logic s_axi_wready_o, // write data ready
  output logic [1:0] s_axi_bresp_o, // write response
  output logic s_axi_bvalid_o, // write response valid
  input wire logic s_axi_bready_i, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr_i, // read address
  input wire logic s_axi_arvalid_i, // read address valid
  output logic s_axi_arready_o, // read address ready
  output logic [31:0] s_axi_rdata_o, // read data
  output logic [1:0] s_axi_rresp_o, // read response
  output logic s_axi_rvalid_o, // read data valid
  input wire logic s_axi_rready_i, // read data ready
  output logic [15:0] comp_zero_negative_lines_o, // one-hot minus mux select, all zero for reserved code 1011
  output logic [15:0] comp_zero_positive_lines_o, // one-hot plus mux select
  output logic [15:0] comp_one_negative_lines_o, // one-hot minus mux select, all zero for reserved code 1011
  output logic [15:0] comp_one_positive_lines_o, // one-hot plus mux select
  output logic half_divider_enable_o // supply half divider on
);
  localparam int IDX_W = ADDR_W - 2;

  // word index of a byte address; low two bits ignored
  function automatic reg_hit_t decode_hit(input logic [ADDR_W-1:0] addr);
    reg_hit_t hit;
    hit = HIT_NONE;
    if (addr[ADDR_W-1:2] == IDX_W'(`CMPSEL_IDX_ZERO)) begin
      hit = HIT_ZERO;
    end else if (addr[ADDR_W-1:2] == IDX_W'(`CMPSEL_IDX_ONE)) begin
      hit = HIT_ONE;
    end
    return hit;
  endfunction

  // write address holding
  logic aw_held_ff;
  logic nxt_aw_held;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [ADDR_W-1:0] nxt_aw_addr;

  // write data holding
  logic w_held_ff;
  logic nxt_w_held;
  sel_byte_t w_data_ff;
  sel_byte_t nxt_w_data;
  logic w_strb_ff;
  logic nxt_w_strb;

  // write response
  logic bvalid_ff;
  logic nxt_bvalid;
  logic [1:0] bresp_ff;
  logic [1:0] nxt_bresp;

  // read channel
  logic rvalid_ff;
  logic nxt_rvalid;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [1:0] rresp_ff;
  logic [1:0] nxt_rresp;

  // divider enable
  logic half_ff;
  logic nxt_half;

  logic aw_take;
  logic w_take;
  logic ar_take;
  logic aw_now;
  logic w_now;
  logic do_write;
  logic [ADDR_W-1:0] wr_addr;
  sel_byte_t wr_byte;
  logic wr_strb;
  reg_hit_t wr_hit;
  reg_hit_t rd_hit;
  logic zero_wr_en;
  logic one_wr_en;
  logic [7:0] zero_q;
  logic [7:0] one_q;

  sel_if zero_neg_if ();
  sel_if zero_pos_if ();
  sel_if one_neg_if ();
  sel_if one_pos_if ();

  // new address and data are refused while a response waits, so one write at a time
  assign s_axi_awready_o = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready_o = !w_held_ff && !bvalid_ff;
  assign s_axi_arready_o = !rvalid_ff;

  assign aw_take = s_axi_awvalid_i && s_axi_awready_o;
  assign w_take = s_axi_wvalid_i && s_axi_wready_o;
  assign ar_take = s_axi_arvalid_i && s_axi_arready_o;

  // the write fires in the cycle its second half arrives
  assign aw_now = aw_held_ff || aw_take;
  assign w_now = w_held_ff || w_take;
  assign do_write = aw_now && w_now && !bvalid_ff;

  assign wr_addr = aw_held_ff ? aw_addr_ff : s_axi_awaddr_i;
  assign wr_byte = w_held_ff ? w_data_ff : s_axi_wdata_i[7:0];
  assign wr_strb = w_held_ff ? w_strb_ff : s_axi_wstrb_i[0];

  always_comb begin
    wr_hit = decode_hit(wr_addr);
    rd_hit = decode_hit(s_axi_araddr_i);
  end

  // only lane 0 carries register bits; upper lanes are dropped
  assign zero_wr_en = do_write && wr_strb && (wr_hit == HIT_ZERO);
  assign one_wr_en = do_write && wr_strb && (wr_hit == HIT_ONE);

  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_aw_addr = aw_addr_ff;
    if (do_write) begin
      nxt_aw_held = 1'b0;
    end else if (aw_take) begin
      nxt_aw_held = 1'b1;
      nxt_aw_addr = s_axi_awaddr_i;
    end
  end

  always_comb begin
    nxt_w_held = w_held_ff;
    nxt_w_data = w_data_ff;
    nxt_w_strb = w_strb_ff;
    if (do_write) begin
      nxt_w_held = 1'b0;
    end else if (w_take) begin
      nxt_w_held = 1'b1;
      nxt_w_data = s_axi_wdata_i[7:0];
      nxt_w_strb = s_axi_wstrb_i[0];
    end
  end

  always_comb begin
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    if (do_write) begin
      nxt_bvalid = 1'b1;
      nxt_bresp = (wr_hit == HIT_NONE) ? `CMPSEL_RESP_SLVERR : `CMPSEL_RESP_OKAY;
    end else if (bvalid_ff && s_axi_bready_i) begin
      nxt_bvalid = 1'b0;
    end
  end

  // unmapped reads answer zero with an error, mapped bits above 7 read zero
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (ar_take) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = `CMPSEL_RESP_OKAY;
      unique case (rd_hit)
        HIT_ZERO: nxt_rdata = {24'h000000, zero_q};
        HIT_ONE: nxt_rdata = {24'h000000, one_q};
        HIT_NONE: begin
          nxt_rdata = 32'h00000000;
          nxt_rresp = `CMPSEL_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && s_axi_rready_i) begin
      nxt_rvalid = 1'b0;
    end
  end

  // divider draws current, so it follows the fields and nothing else
  always_comb begin
    nxt_half = zero_neg_if.half_req || zero_pos_if.half_req
      || one_neg_if.half_req || one_pos_if.half_req;
  end

  // write address holding register
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= '0;
    end else begin
      aw_held_ff <= nxt_aw_held;
      aw_addr_ff <= nxt_aw_addr;
    end
  end

  // write data holding register
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      w_held_ff <= 1'b0;
      w_data_ff <= 8'h00;
      w_strb_ff <= 1'b0;
    end else begin
      w_held_ff <= nxt_w_held;
      w_data_ff <= nxt_w_data;
      w_strb_ff <= nxt_w_strb;
    end
  end

  // write response register
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `CMPSEL_RESP_OKAY;
    end else begin
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
    end
  end

  // read response register; data reset keeps the bus free of unknowns
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `CMPSEL_RESP_OKAY;
    end else begin
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  // divider enable register
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      half_ff <= 1'b0;
    end else begin
      half_ff <= nxt_half;
    end
  end

  sel_reg zero_reg (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .wr_en_i (zero_wr_en),
    .wr_data_i (wr_byte),
    .q_o (zero_q)
  );

  sel_reg one_reg (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .wr_en_i (one_wr_en),
    .wr_data_i (wr_byte),
    .q_o (one_q)
  );

  assign zero_neg_if.code = zero_q[`CMPSEL_NEG_MSB:`CMPSEL_NEG_LSB];
  assign zero_pos_if.code = zero_q[`CMPSEL_POS_MSB:`CMPSEL_POS_LSB];
  assign one_neg_if.code = one_q[`CMPSEL_NEG_MSB:`CMPSEL_NEG_LSB];
  assign one_pos_if.code = one_q[`CMPSEL_POS_MSB:`CMPSEL_POS_LSB];

  // stored code stays as written; only the decoded lines are masked
  input_select_decoder #(.RESERVED_MASK (`CMPSEL_NEG_RSVD_MASK)) zero_neg_dec (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .sel (zero_neg_if)
  );

  input_select_decoder #(.RESERVED_MASK (`CMPSEL_POS_RSVD_MASK)) zero_pos_dec (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .sel (zero_pos_if)
  );

  // same parameters as comparator zero, so both decode alike
  input_select_decoder #(.RESERVED_MASK (`CMPSEL_NEG_RSVD_MASK)) one_neg_dec (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .sel (one_neg_if)
  );

  input_select_decoder #(.RESERVED_MASK (`CMPSEL_POS_RSVD_MASK)) one_pos_dec (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .sel (one_pos_if)
  );

  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o = bresp_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rdata_o = rdata_ff;
  assign s_axi_rresp_o = rresp_ff;
  assign comp_zero_negative_lines_o = zero_neg_if.lines;
  assign comp_zero_positive_lines_o = zero_pos_if.lines;
  assign comp_one_negative_lines_o = one_neg_if.lines;
  assign comp_one_positive_lines_o = one_pos_if.lines;
  assign half_divider_enable_o = half_ff;
endmodule
`default_nettype wire

// ===== dv/comparator_input_select_regs_sva.sv
// port-level assertions for the comparator input select bank
`default_nettype none
module comparator_input_select_regs_sva (
  input wire logic clock_i, // clock
  input wire logic rst_n_i, // reset
  input wire logic s_axi_awvalid_i, // aw
  input wire logic s_axi_awready_o, // aw
  input wire logic s_axi_wvalid_i, // w
  input wire logic s_axi_wready_o, // w
  input wire logic [1:0] s_axi_bresp_o, // b
  input wire logic s_axi_bvalid_o, // b
  input wire logic s_axi_bready_i, // b
  input wire logic s_axi_arvalid_i, // ar
  input wire logic s_axi_arready_o, // ar
  input wire logic [31:0] s_axi_rdata_o, // r
  input wire logic s_axi_rvalid_o, // r
  input wire logic s_axi_rready_i, // r
  input wire logic [15:0] comp_zero_negative_lines_o, // mux
  input wire logic [15:0] comp_zero_positive_lines_o, // mux
  input wire logic [15:0] comp_one_negative_lines_o, // mux
  input wire logic [15:0] comp_one_positive_lines_o, // mux
  input wire logic half_divider_enable_o // divider
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_zero_neg_lines: assert property ($onehot0(comp_zero_negative_lines_o) && !comp_zero_negative_lines_o[11])
    else $error("zero minus lines bad");
  a_zero_pos_lines: assert property ($onehot(comp_zero_positive_lines_o))
    else $error("zero plus lines bad");
  a_one_neg_lines: assert property ($onehot0(comp_one_negative_lines_o) && !comp_one_negative_lines_o[11])
    else $error("one minus lines bad");
  a_one_pos_lines: assert property ($onehot(comp_one_positive_lines_o))
    else $error("one plus lines bad");
  a_half_divider: assert property (1'b1 |=> half_divider_enable_o == $past(comp_zero_negative_lines_o[13]
    | comp_zero_positive_lines_o[13] | comp_one_negative_lines_o[13] | comp_one_positive_lines_o[13]))
    else $error("divider enable wrong");
  a_reset_lines: assert property ($rose(rst_n_i) |-> comp_zero_negative_lines_o == 16'h8000
    && comp_one_positive_lines_o == 16'h8000 && !half_divider_enable_o) else $error("reset state wrong");
  a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    |=> s_axi_bvalid_o) else $error("no write response");
  a_write_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("no read response");
  a_read_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped");
endmodule
bind comparator_input_select_regs comparator_input_select_regs_sva i_comparator_input_select_regs_sva (.clock_i,
  .rst_n_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
  .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i,
  .comp_zero_negative_lines_o, .comp_zero_positive_lines_o, .comp_one_negative_lines_o,
  .comp_one_positive_lines_o, .half_divider_enable_o);
`default_nettype wire

// ===== dv/comparator_input_select_regs_tb.sv
// self-checking bench for the comparator input select bank
`default_nettype none
module comparator_input_select_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i, rst_n_i, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid, half;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [15:0] zn, zp, yn, yp;
  logic [7:0] lz, lo;
  int miscompares, n_compared, i;
  integer seed;
  localparam logic [11:0] A_ZERO = 12'h9F << 2;
  localparam logic [11:0] A_ONE = 12'h9E << 2;
  comparator_input_select_regs i_comparator_input_select_regs (.clock_i, .rst_n_i,
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .comp_zero_negative_lines_o(zn), .comp_zero_positive_lines_o(zp),
    .comp_one_negative_lines_o(yn), .comp_one_positive_lines_o(yp), .half_divider_enable_o(half));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] dec(input logic [3:0] c, input bit neg);
    return (neg && c == 4'hB) ? 16'h0000 : 16'h0001 << c;
  endfunction
  // handshakes sampled at negedge so the decision never races the clock edge
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s, output logic [1:0] rs);
    bit ta, tw, bv;
    int k;
    awaddr <= a; wdata <= v; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1; bv = 0; k = 0;
    // only the watchdog ends a wait that never gets its answer
    while (!bv) begin
      @(negedge clock_i);
      ta = awvalid && awready; tw = wvalid && wready; bv = bvalid; rs = bresp; k++;
      @(posedge clock_i);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (bv) bready <= 1'b0;
    end
    chk(32'(k), 32'h2);
    @(posedge clock_i);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q, output logic [1:0] rs);
    bit tr, tv;
    int k;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1; tv = 0; k = 0;
    while (!tv) begin
      @(negedge clock_i);
      tr = arvalid && arready; tv = rvalid; q = rdata; rs = rresp; k++;
      @(posedge clock_i);
      if (tr) arvalid <= 1'b0;
      if (tv) rready <= 1'b0;
    end
    chk(32'(k), 32'h2);
    @(posedge clock_i);
  endtask
  task automatic expect_all(input logic [7:0] z, input logic [7:0] o);
    @(negedge clock_i);
    chk(32'(zn), 32'(dec(z[7:4], 1)));
    chk(32'(zp), 32'(dec(z[3:0], 0)));
    chk(32'(yn), 32'(dec(o[7:4], 1)));
    chk(32'(yp), 32'(dec(o[3:0], 0)));
    chk(32'(half), 32'(z[7:4] == 4'hD || z[3:0] == 4'hD || o[7:4] == 4'hD || o[3:0] == 4'hD));
    @(posedge clock_i);
    rd(A_ZERO, d, r);
    chk(d, {24'h000000, z});
    chk(32'(r), 32'h0);
    rd(A_ONE, d, r);
    chk(d, {24'h000000, o});
    chk(32'(r), 32'h0);
  endtask
  task automatic apply(input logic [7:0] z, input logic [7:0] o);
    d = $random(seed);
    wr(A_ZERO, {d[31:8], z}, {d[3:1], 1'b1}, r);
    chk(32'(r), 32'h0);
    wr(A_ONE, {d[23:0], o}, 4'hF, r);
    chk(32'(r), 32'h0);
    lz = z;
    lo = o;
    expect_all(z, o);
  endtask
  initial begin
    repeat (20000) @(posedge clock_i);
    miscompares++;
    summarize();
  end
  initial begin
    seed = 32'hB50D9ECF;
    {awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready, arvalid, rready} = '0;
    rst_n_i = 1'b0; miscompares = 0; n_compared = 0;
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    expect_all(8'hFF, 8'hFF);
    for (i = 0; i < 16; i++) apply({i[3:0], ~i[3:0]}, {~i[3:0], i[3:0]});
    repeat (20) apply(8'($random(seed)), 8'($random(seed)));
    // low strobe clear: store must be skipped yet answered OKAY
    wr(A_ZERO, 32'h0000005A, 4'hE, r);
    chk(32'(r), 32'h0);
    wr(12'h280, 32'h00000055, 4'hF, r);
    chk(32'(r), 32'h2);
    rd(12'h280, d, r);
    chk(d, 32'h0);
    chk(32'(r), 32'h2);
    expect_all(lz, lo);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    expect_all(8'hFF, 8'hFF);
    summarize();
  end
endmodule
`default_nettype wire
